// [include/cbia_pkg.sv]
// Constants, register layout and carrier types of the card bus controller.
// Assumes a single 25 MHz clock domain and a plain register port.
package cbia_pkg;
    // ==========================================================
    // Register offsets and reset values
    localparam logic [7:0] OFS_BUS_ONE = 8'h60;
    localparam logic [7:0] OFS_BUS_TWO = 8'h62;
    localparam logic [7:0] OFS_WAIT_ONE = 8'h64;
    localparam logic [7:0] OFS_WAIT_TWO = 8'h66;
    localparam logic [7:0] OFS_CARD_TIMING = 8'h6E;
    localparam logic [15:0] RST_BUS_ONE = 16'h0000;
    localparam logic [15:0] RST_BUS_TWO = 16'h3FF0;
    localparam logic [15:0] RST_WAIT_ONE = 16'h3FF3;
    localparam logic [15:0] RST_WAIT_TWO = 16'hFFFF;
    localparam logic [15:0] RST_CARD_TIMING = 16'h0000;
    localparam logic [15:0] MSK_BUS_ONE = 16'hF7FF;
    localparam logic [15:0] MSK_BUS_TWO = 16'h3FF0;
    // ==========================================================
    // Field positions
    localparam int B1_ADDRESS_PULLUP_ENABLE = 15;
    localparam int B1_DATA_PULLUP_ENABLE = 14;
    localparam int B1_ENDIAN = 11;
    localparam int B1_A5BST = 7;
    localparam int B1_A6BST = 5;
    localparam int B1_A5SEL = 1;
    localparam int B1_A6SEL = 0;
    localparam int B2_A5SZ = 10;
    localparam int B2_A6SZ = 12;
    localparam int WC2_A5 = 0;
    localparam int WC2_A6 = 3;
    localparam int CT_A5_SETUP = 0;
    localparam int CT_A5_HOLD = 2;
    localparam int CT_A6_SETUP = 4;
    localparam int CT_A6_HOLD = 6;
    localparam logic [1:0] SZ_8BIT = 2'h1;
    // ==========================================================
    // Address map
    localparam logic [2:0] AREA5 = 3'h5;
    localparam logic [2:0] AREA6 = 3'h6;
    localparam logic [3:0] IO5_TOP = 4'hB;
    localparam logic [3:0] IO6_TOP = 4'hD;
    // ==========================================================
    // Timing and widths
    localparam logic [2:0] PULLUP_CLOCKS = 3'h4;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    localparam logic [1:0] STRAP_TAKE = 2'h2;
    localparam int SYNC_W = 20;
    // Synchroniser reset levels: release request and wait pins idle high.
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 20'h0_000A;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE, ST_GAP, ST_SETUP, ST_STROBE, ST_HOLD, ST_REL
    } cbia_state_e;
    typedef struct packed {
        logic [28:0] addr;
        logic write;
        logic word;
        logic [15:0] wdata;
        logic [3:0] beats_m1;
        logic no_wait;
        logic lock;
    } cbia_req_s;
    typedef struct packed {
        logic [15:0] rdata;
        logic last;
    } cbia_rsp_s;
endpackage

// [rtl/cbia_card_bus.sv]
// Card bus controller for areas 5 and 6: card cycles, idle insertion,
// bus release arbitration and pin pull-up control.
// Assumes one 25 MHz clock, a plain register port and pins from outside.
//
// Functional notes
// - Area 5 select makes card cycles
// - Area 6 select makes card cycles
// - Card areas are 8 or 16 bit
// - Some transfers ignore the wait pin
// - Non I/O card access uses memory timing
// - Card setup and hold from timing register
// - Software and hardware waits in card cycles
// - Page burst for memory card reads only
// - A24 selects attribute memory half; A24 is not decoded here and only passes to the address pins
// - Area 5 upper half is I/O
// - Area 6 upper half is I/O
// - Narrow I/O word splits into two bytes; width sense pin used in little endian only
// - Idle cycles on area change or turnaround
// - No idle between writes or same reads
// - Idle count minus existing empty cycles
// - No idle cycles around arbitration
// - Release finishes cycle then grants bus
// - No grant in locked or split sequences
// - Request negation ends grant, bus resumes
// - Address pull-up four clocks after grant
// - Data pull-up while data bus idle
// - Endian pin captured at reset
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module cbia_card_bus (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_q,
    // Access requests from the core
    input wire logic req_valid,
    input wire cbia_pkg::cbia_req_s req,
    output logic req_ready_q,
    output logic rsp_valid_q,
    output cbia_pkg::cbia_rsp_s rsp_q,
    // Address and data pins
    output logic [25:0] pin_addr_q,
    output logic addr_oe_q,
    output logic addr_pullup_q,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out_q,
    output logic data_oe_q,
    output logic data_pullup_q,
    // Card control pins
    output logic area5_chip_select_n_q,
    output logic area6_chip_select_n_q,
    output logic area5_upper_card_enable_n_q,
    output logic area6_upper_card_enable_n_q,
    output logic rd_n_q,
    output logic we_n_q,
    output logic io_rd_n_q,
    output logic io_wr_n_q,
    input wire logic wait_n,
    input wire logic io_width_sense_n,
    // Arbitration and strap pins
    input wire logic bus_release_request_n,
    output logic bus_grant_n_q,
    input wire logic endian_select_pin
);
    import cbia_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    wire [SYNC_W-1:0] pins_raw = {data_in, wait_n, io_width_sense_n,
                                  bus_release_request_n, endian_select_pin};
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    // Idle levels avoid a false release request after reset.
                    meta_q[g] <= SYNC_IDLE[g];
                    sync_q[g] <= SYNC_IDLE[g];
                end else begin
                    meta_q[g] <= pins_raw[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate
    wire endian_s = sync_q[0];
    wire bus_release_request_s = !sync_q[1];
    wire iow8_s = sync_q[2];
    wire wait_s = !sync_q[3];
    wire [15:0] data_s = sync_q[19:4];

    // ==========================================================
    // Registers and state
    logic [15:0] bus_one_q;
    logic [15:0] bus_two_q;
    logic [15:0] wait_one_q;
    logic [15:0] wait_two_q;
    logic [15:0] timing_q;
    logic endian_q;
    logic [1:0] strap_q;
    cbia_state_e state_q;
    cbia_state_e state_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    cbia_req_s cur_q;
    logic card_q;
    logic io_q;
    logic split_q;
    logic half_q;
    logic [3:0] beat_q;
    logic [1:0] empty_q;
    logic [2:0] last_area_q;
    logic last_read_q;
    logic last_valid_q;
    logic lock_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [2:0] pull_cnt_q;
    logic [2:0] pull_cnt_d;

    // ==========================================================
    // Register decode
    wire sel_b1 = reg_addr == OFS_BUS_ONE;
    wire sel_b2 = reg_addr == OFS_BUS_TWO;
    wire sel_w1 = reg_addr == OFS_WAIT_ONE;
    wire sel_w2 = reg_addr == OFS_WAIT_TWO;
    wire sel_ct = reg_addr == OFS_CARD_TIMING;
    wire [15:0] bus_one_rd = bus_one_q | (16'(endian_q) << B1_ENDIAN);
    wire [15:0] rd_mux = sel_b1 ? bus_one_rd :
                         sel_b2 ? bus_two_q :
                         sel_w1 ? wait_one_q :
                         sel_w2 ? wait_two_q :
                         sel_ct ? timing_q : 16'h0000;
    wire address_pullup_enable = bus_one_q[B1_ADDRESS_PULLUP_ENABLE];
    wire data_pullup_enable = bus_one_q[B1_DATA_PULLUP_ENABLE];
    wire cap_done = strap_q == STRAP_DONE;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_one_q <= RST_BUS_ONE;
            bus_two_q <= RST_BUS_TWO;
            wait_one_q <= RST_WAIT_ONE;
            wait_two_q <= RST_WAIT_TWO;
            timing_q <= RST_CARD_TIMING;
            reg_rdata_q <= 16'h0000;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : 16'h0000;
            if (reg_wr) begin
                if (sel_b1) begin
                    bus_one_q <= reg_wdata & MSK_BUS_ONE;
                end else if (sel_b2) begin
                    bus_two_q <= reg_wdata & MSK_BUS_TWO;
                end else if (sel_w1) begin
                    wait_one_q <= reg_wdata;
                end else if (sel_w2) begin
                    wait_two_q <= reg_wdata;
                end else if (sel_ct) begin
                    timing_q <= reg_wdata;
                end
            end
        end
    end

    // endian strap capture
    // The pin is taken once its synchroniser has filled after release.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_q <= 2'h0;
            endian_q <= 1'b0;
        end else if (!cap_done) begin
            strap_q <= strap_q + 2'h1;
            if (strap_q == STRAP_TAKE) begin
                endian_q <= endian_s;
            end
        end
    end

    // ==========================================================
    // Request decode
    wire [2:0] rq_area = req.addr[28:26];
    wire rq_a5 = rq_area == AREA5;
    wire rq_a6 = rq_area == AREA6;
    wire [3:0] rq_top = req.addr[28:25];
    wire rq_card = (rq_a5 && bus_one_q[B1_A5SEL]) || (rq_a6 && bus_one_q[B1_A6SEL]);
    wire rq_io = rq_card && ((rq_a5 && rq_top == IO5_TOP) || (rq_a6 && rq_top == IO6_TOP));
    wire take = req_valid && req_ready_q;
    wire need_gap = last_valid_q && (rq_area != last_area_q || (last_read_q && req.write));
    wire [1:0] last_idle = wait_one_q[{last_area_q, 1'b0} +: 2];
    wire [1:0] gap_left = (need_gap && last_idle > empty_q) ? last_idle - empty_q : 2'h0;

    // ==========================================================
    // Current access decode
    wire cur_a5 = cur_q.addr[28:26] == AREA5;
    wire cur_a6 = cur_q.addr[28:26] == AREA6;
    wire [1:0] cur_sz = cur_a5 ? bus_two_q[B2_A5SZ +: 2] : bus_two_q[B2_A6SZ +: 2];
    wire port8 = (cur_a5 || cur_a6) && cur_sz == SZ_8BIT;
    wire [1:0] setup_n = !card_q ? 2'h0 :
                         cur_a5 ? timing_q[CT_A5_SETUP +: 2] : timing_q[CT_A6_SETUP +: 2];
    wire [1:0] hold_n = !card_q ? 2'h0 :
                        cur_a5 ? timing_q[CT_A5_HOLD +: 2] : timing_q[CT_A6_HOLD +: 2];
    wire [2:0] sw_n = cur_a5 ? wait_two_q[WC2_A5 +: 3] :
                      cur_a6 ? wait_two_q[WC2_A6 +: 3] : 3'h0;
    wire [1:0] bst = cur_a5 ? bus_one_q[B1_A5BST +: 2] : bus_one_q[B1_A6BST +: 2];
    wire page = card_q && !io_q && !cur_q.write && bst != 2'h0;
    wire more = beat_q != cur_q.beats_m1;
    wire hw_wait = wait_s && !cur_q.no_wait;
    wire dyn8 = io_q && cur_q.word && !port8 && endian_q && iow8_s;
    wire strobe_end = state_q == ST_STROBE && cnt_q == 3'h0 && !hw_wait;
    wire hold_end = state_q == ST_HOLD && cnt_q == 3'h0;
    wire half_pend = split_q && !half_q;
    wire beat_done = page ? strobe_end : hold_end && !half_pend;
    wire byte_x = !cur_q.word || port8 || split_q;
    wire hi_sel = split_q && (half_q ^ !endian_q);
    wire act = state_q == ST_SETUP || state_q == ST_STROBE || state_q == ST_HOLD;
    wire [25:0] beat_ofs = cur_q.word ? {21'h0, beat_q, 1'b0} : {22'h0, beat_q};
    wire [25:0] addr_d = cur_q.addr[25:0] + beat_ofs + {25'h0, half_q};
    wire grant_ok = bus_release_request_s && !lock_q;

    // ==========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_GAP;
                    cnt_d = {1'b0, gap_left};
                end else if (grant_ok) begin
                    state_d = ST_REL;
                end
            end
            ST_GAP: begin
                if (cnt_q == 3'h0) begin
                    state_d = ST_SETUP;
                    cnt_d = {1'b0, setup_n};
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ST_SETUP: begin
                if (cnt_q == 3'h0) begin
                    state_d = ST_STROBE;
                    cnt_d = sw_n;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ST_STROBE: begin
                if (cnt_q != 3'h0) begin
                    cnt_d = cnt_q - 3'h1;
                end else if (!hw_wait) begin
                    if (page && more) begin
                        cnt_d = sw_n;
                    end else begin
                        state_d = ST_HOLD;
                        cnt_d = {1'b0, hold_n};
                    end
                end
            end
            ST_HOLD: begin
                if (cnt_q != 3'h0) begin
                    cnt_d = cnt_q - 3'h1;
                end else if (half_pend || more) begin
                    state_d = ST_SETUP;
                    cnt_d = {1'b0, setup_n};
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_REL: begin
                if (!bus_release_request_s) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        rdata_d = rdata_q;
        if (strobe_end && !cur_q.write) begin
            if (!byte_x) begin
                rdata_d = data_s;
            end else if (hi_sel) begin
                rdata_d[15:8] = data_s[7:0];
            end else begin
                rdata_d[7:0] = data_s[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            req_ready_q <= 1'b0;
            rdata_q <= 16'h0000;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            req_ready_q <= state_d == ST_IDLE && cap_done;
            rdata_q <= rdata_d;
            rsp_valid_q <= beat_done;
            rsp_q <= '{rdata: rdata_d, last: !more};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_q <= '0;
            card_q <= 1'b0;
            io_q <= 1'b0;
            lock_q <= 1'b0;
        end else if (take) begin
            cur_q <= req;
            card_q <= rq_card;
            io_q <= rq_io;
            lock_q <= req.lock;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            split_q <= 1'b0;
            half_q <= 1'b0;
            beat_q <= 4'h0;
        end else if (take) begin
            split_q <= 1'b0;
            half_q <= 1'b0;
            beat_q <= 4'h0;
        end else if (state_q == ST_GAP) begin
            split_q <= cur_q.word && port8;
        end else if (strobe_end && dyn8 && !half_q) begin
            split_q <= 1'b1;
        end else if (hold_end && half_pend) begin
            half_q <= 1'b1;
        end else if (beat_done && more) begin
            beat_q <= beat_q + 4'h1;
            half_q <= 1'b0;
            split_q <= cur_q.word && port8;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_valid_q <= 1'b0;
            last_area_q <= 3'h0;
            last_read_q <= 1'b0;
            empty_q <= 2'h0;
        end else if (state_q == ST_REL) begin
            last_valid_q <= 1'b0;
        end else if (hold_end && state_d == ST_IDLE) begin
            last_valid_q <= 1'b1;
            last_area_q <= cur_q.addr[28:26];
            last_read_q <= !cur_q.write;
            empty_q <= 2'h0;
        end else if (state_q == ST_IDLE && !take && empty_q != 2'h3) begin
            empty_q <= empty_q + 2'h1;
        end
    end

    // ==========================================================
    // Pin drivers
    // four clock address pull-up
    assign pull_cnt_d = (state_q == ST_REL && bus_grant_n_q) ? PULLUP_CLOCKS :
                        pull_cnt_q != 3'h0 ? pull_cnt_q - 3'h1 : 3'h0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pull_cnt_q <= 3'h0;
            addr_pullup_q <= 1'b0;
            bus_grant_n_q <= 1'b1;
            addr_oe_q <= 1'b1;
            pin_addr_q <= 26'h0;
            data_out_q <= 16'h0000;
            data_oe_q <= 1'b0;
            data_pullup_q <= 1'b0;
        end else begin
            pull_cnt_q <= pull_cnt_d;
            addr_pullup_q <= address_pullup_enable && pull_cnt_d != 3'h0;
            bus_grant_n_q <= state_q != ST_REL;
            addr_oe_q <= state_q != ST_REL;
            pin_addr_q <= addr_d;
            data_out_q <= !byte_x ? cur_q.wdata :
                          {8'h00, hi_sel ? cur_q.wdata[15:8] : cur_q.wdata[7:0]};
            data_oe_q <= act && cur_q.write;
            data_pullup_q <= data_pullup_enable && !act;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            area5_chip_select_n_q <= 1'b1;
            area6_chip_select_n_q <= 1'b1;
            area5_upper_card_enable_n_q <= 1'b1;
            area6_upper_card_enable_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            we_n_q <= 1'b1;
            io_rd_n_q <= 1'b1;
            io_wr_n_q <= 1'b1;
        end else begin
            area5_chip_select_n_q <= !(act && cur_a5);
            area6_chip_select_n_q <= !(act && cur_a6);
            area5_upper_card_enable_n_q <= !(act && cur_a5 && card_q && !byte_x);
            area6_upper_card_enable_n_q <= !(act && cur_a6 && card_q && !byte_x);
            rd_n_q <= !(state_q == ST_STROBE && !cur_q.write && !io_q);
            we_n_q <= !(state_q == ST_STROBE && cur_q.write && !io_q);
            io_rd_n_q <= !(state_q == ST_STROBE && !cur_q.write && io_q);
            io_wr_n_q <= !(state_q == ST_STROBE && cur_q.write && io_q);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_gap_two;
        state_q == ST_GAP [*3] ##1 state_q == ST_SETUP;
    endsequence
    sequence s_pull_four;
        addr_pullup_q [*4] ##1 !addr_pullup_q;
    endsequence

    AST_GRANT_ONLY_RELEASED: assert property (
        !bus_grant_n_q |-> $past(state_q) == ST_REL && addr_oe_q == 1'b0)
        else $error("Grant seen outside released state.");
    AST_GRANT_ENDS: assert property (
        state_q == ST_REL && !bus_release_request_s |=> state_q == ST_IDLE ##1 bus_grant_n_q)
        else $error("Grant not withdrawn after request negation.");
    AST_LOCK_BLOCKS: assert property (
        state_q == ST_IDLE && lock_q && !take |=> state_q != ST_REL)
        else $error("Bus released during locked sequence.");
    AST_PULLUP_LEN: assert property (
        $fell(bus_grant_n_q) && address_pullup_enable && bus_release_request_s |-> s_pull_four)
        else $error("Address pull-up not four clocks.");
    AST_DATA_PULL: assert property (
        data_oe_q |-> !data_pullup_q)
        else $error("Data pull-up while driving data.");
    AST_GAP_COUNT: assert property (
        take && gap_left == 2'h2 |=> s_gap_two)
        else $error("Wrong number of idle cycles.");
    AST_WRITE_NO_GAP: assert property (
        take && req.write && last_valid_q && !last_read_q
        && rq_area == last_area_q |=> state_q == ST_GAP ##1 state_q == ST_SETUP)
        else $error("Idle cycle inserted between writes.");
    AST_WAIT_IGNORED: assert property (
        state_q == ST_STROBE && cnt_q == 3'h0 && cur_q.no_wait && !page
        |=> state_q == ST_HOLD)
        else $error("Wait pin honoured on no-wait transfer.");
    AST_SPLIT_SECOND: assert property (
        hold_end && half_pend |=> state_q == ST_SETUP && half_q)
        else $error("Second byte transfer not issued.");
    AST_ENDIAN_STABLE: assert property (
        cap_done |=> $stable(endian_q))
        else $error("Endian flag changed after capture.");

endmodule

// [test/cbia_card_model.sv]
// Card socket model: answers read strobes with address-derived data.
// Assumes active low strobes; the card never asks for hardware waits.
`timescale 1ns/1ps
module cbia_card_model (
    // Pins from the controller
    input wire logic [25:0] pin_addr,
    input wire logic rd_n,
    input wire logic io_rd_n,
    // Pins to the controller
    output logic [15:0] data_out,
    output logic wait_n
);
    logic [15:0] held;
    // ==========================================================
    // Card data
    // A released data bus shows the inverse of the last value, never a stale copy.
    assign wait_n = 1'b1;
    always @(rd_n or io_rd_n or pin_addr) begin
        if (!rd_n || !io_rd_n) begin
            held = pin_addr[15:0] ^ 16'hA5A5;
        end
    end
    assign data_out = (!rd_n || !io_rd_n) ? held : ~held;
endmodule

// [test/test_cbia_card_bus.sv]
// Testbench for the card bus controller: registers, card reads, release.
// Assumes the card model above on the pins and a little-endian strap.
`timescale 1ns/1ps
module test_cbia_card_bus;
    import cbia_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic req_valid = 1'b0;
    logic bus_release_request_n = 1'b1;
    logic io_width_sense_n = 1'b0;
    logic endian_select_pin = 1'b1;
    cbia_req_s req = '0;
    cbia_rsp_s rsp_q;
    logic [15:0] reg_rdata_q, data_in;
    logic [25:0] pin_addr_q;
    logic req_ready_q, rsp_valid_q, addr_oe_q, addr_pullup_q, data_oe_q, data_pullup_q;
    logic rd_n_q, io_rd_n_q, wait_n, bus_grant_n_q, seen_rd, seen_io;
    int err_total = 0;
    int num_checks = 0;
    int pu_cnt = 0;
    always #20 clk = ~clk;
    cbia_card_bus dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .req_valid, .req, .req_ready_q, .rsp_valid_q, .rsp_q, .pin_addr_q, .addr_oe_q,
        .addr_pullup_q, .data_in, .data_out_q(), .data_oe_q, .data_pullup_q,
        .area5_chip_select_n_q(), .area6_chip_select_n_q(), .area5_upper_card_enable_n_q(),
        .area6_upper_card_enable_n_q(), .rd_n_q, .we_n_q(), .io_rd_n_q, .io_wr_n_q(),
        .wait_n, .io_width_sense_n, .bus_release_request_n, .bus_grant_n_q,
        .endian_select_pin);
    cbia_card_model card (.pin_addr(pin_addr_q), .rd_n(rd_n_q), .io_rd_n(io_rd_n_q),
        .data_out(data_in), .wait_n(wait_n));
    always @(posedge clk) begin
        if (rd_n_q === 1'b0) seen_rd <= 1'b1;
        if (io_rd_n_q === 1'b0) seen_io <= 1'b1;
        if (addr_pullup_q === 1'b1) pu_cnt <= pu_cnt + 1;
    end
    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Register port and request port
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(reg_rdata_q, exp);
    endtask
    task automatic acc(input logic [28:0] a, input logic [15:0] exp, input logic [1:0] kind);
        int i;
        seen_rd = 1'b0;
        seen_io = 1'b0;
        i = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{addr: a, write: 1'b0, word: 1'b1, wdata: 16'h0000, beats_m1: 4'h0,
                 no_wait: 1'b0, lock: 1'b0};
        do @(posedge clk); while (req_ready_q !== 1'b1 && ++i < 60);
        req_valid <= 1'b0;
        i = 0;
        do @(posedge clk); while (rsp_valid_q !== 1'b1 && ++i < 200);
        chk(rsp_q.rdata, exp);
        chk(16'({seen_rd, seen_io}), 16'(kind));
        chk(16'(rsp_q.last), 16'h0001);
        chk(pin_addr_q[15:0], a[15:0]);
        chk(16'(data_oe_q), 16'h0000);
    endtask
    task automatic wgnt(input logic v);
        int i;
        for (i = 0; i < 30 && bus_grant_n_q !== v; i++) @(posedge clk);
        chk(16'(bus_grant_n_q), 16'(v));
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h62, 16'h3FF0);
        rd(8'h64, 16'h3FF3);
        rd(8'h66, 16'hFFFF);
        rd(8'h70, 16'h0000);
        wr(8'h60, 16'h0000);
        rd(8'h60, 16'h0800);
        wr(8'h60, 16'h8002);
        acc(29'h1400_0010, 16'hA5B5, 2'h2);
        acc(29'h1600_0020, 16'hA585, 2'h1);
        wr(8'h60, 16'hC002);
        repeat (3) @(posedge clk);
        chk(16'(data_pullup_q), 16'h0001);
        pu_cnt = 0;
        bus_release_request_n <= 1'b0;
        wgnt(1'b0);
        repeat (12) @(posedge clk);
        chk(16'(addr_oe_q), 16'h0000);
        chk(16'(pu_cnt), 16'h0004);
        bus_release_request_n <= 1'b1;
        wgnt(1'b1);
        acc(29'h1400_0010, 16'hA5B5, 2'h2);
        print_verdict();
    end
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule
